// [logic/ipsl_cfg.svh]
// Offsets, field positions, reset values and vector numbers of the interrupt priority and status logic.
// Assumes a 32-bit AXI4-Lite register bus with each register in one aligned word.
`ifndef IPSL_CFG_SVH
`define IPSL_CFG_SVH

`define IPSL_ADDR_W          8
`define IPSL_OFF_I2C_TWO     8'h00
`define IPSL_OFF_CALENDAR    8'h04
`define IPSL_OFF_CHK_SERIAL  8'h08
`define IPSL_OFF_LOW_VOLT    8'h0c
`define IPSL_OFF_STATUS      8'h10

`define IPSL_NUM_SRC         7
`define IPSL_NUM_TRAP        8
`define IPSL_LEVEL_RESET     3'h4
`define IPSL_LEVEL_OFF       3'h0
`define IPSL_LEVEL_TOP_USER  4'h7
`define IPSL_TRAP_BASE_LVL   4'h8
`define IPSL_VEC_BASE        8'h08

`define IPSL_POS_HI          12
`define IPSL_POS_MID         8
`define IPSL_POS_LO          4
`define IPSL_POS_BOTTOM      0
`define IPSL_POS_UNACK       15
`define IPSL_POS_VECTOR_CAPTURE_SELECT       13
`define IPSL_POS_CPU_LVL     8

// Vector numbers of the user sources, in source index order.
`define IPSL_VEC_I2C_MASTER  8'h39
`define IPSL_VEC_I2C_SLAVE   8'h3a
`define IPSL_VEC_CALENDAR    8'h3b
`define IPSL_VEC_CHECKSUM    8'h3c
`define IPSL_VEC_SERIAL_TWO  8'h3d
`define IPSL_VEC_SERIAL_ONE  8'h3e
`define IPSL_VEC_LOW_VOLT    8'h48

`define IPSL_RESP_OKAY       2'h0
`define IPSL_RESP_SLVERR     2'h2

`endif

// [logic/ipsl_pkg.sv]
// Types shared by the interrupt priority and status logic.
// Assumes ipsl_cfg.svh is on the include path.
`include "ipsl_cfg.svh"

package ipsl_pkg;

    typedef logic [`IPSL_NUM_SRC-1:0][2:0] ipsl_levels_t;

    typedef struct packed {
        ipsl_levels_t                 lvl;
        logic                         vector_capture_select;
        logic                         unack;
        logic [3:0]                   cpu_lvl;
        logic [6:0]                   vec;
        logic                         irq_req;
        logic [3:0]                   irq_level;
        logic [7:0]                   irq_vector;
        logic                         aw_held;
        logic [`IPSL_ADDR_W-1:0]      awaddr;
        logic                         w_held;
        logic [31:0]                  wdata;
        logic [3:0]                   wstrb;
        logic                         awready;
        logic                         wready;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         arready;
        logic                         rvalid;
        logic [31:0]                  rdata;
        logic [1:0]                   rresp;
    } ipsl_state_t;

endpackage

// [logic/ipsl_top.sv]
// Interrupt priority registers, status readback and request arbitration toward the processor core.
// Assumes flags, enables, traps and core status arrive from logic on the same clock.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "ipsl_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Three-bit priority field holds the level directly, seven highest, one lowest.
// - A zero priority field disables its source completely.
// - Every priority field resets to level four.
// - Unimplemented bits read zero and ignore writes.
// - Status top bit shows a request held off by an equal or higher processor level while nothing is presented.
// - With capture select set, vector field tracks the highest pending user interrupt.
// - With capture select clear, vector field holds the last acknowledged user interrupt; traps are not captured.
// - Four-bit read-only field shows the processor level, zero to fifteen.
// - Vector field holds vector number minus eight.
// - A flag still set after return requests the interrupt again at once.
// - Core restores state and level on return; routines end with that return.
// - Traps at levels eight to fifteen are never masked.
// - Processor level seven masks all user interrupts.
// - Timed mask blocks levels one to six but not level seven.
// - Nesting disable stops a user request pre-empting a running routine; traps still pre-empt.
// - Second two-wire bus master level at bits 10-8, slave level at 6-4.
// - Checksum error at 14-12, serial two error 10-8, serial one error 6-4.
// - Calendar level at bits 10-8, low voltage level at bits 2-0.
module ipsl_top (
    input  wire logic                        clk,             // System clock, 125 MHz.
    input  wire logic                        rst,             // Asynchronous reset, active high.
    input  wire logic [`IPSL_ADDR_W-1:0]     s_axi_awaddr,    // Write address.
    input  wire logic                        s_axi_awvalid,   // Write address valid.
    output logic                             s_axi_awready,   // Write address ready.
    input  wire logic [31:0]                 s_axi_wdata,     // Write data.
    input  wire logic [3:0]                  s_axi_wstrb,     // Write byte strobes.
    input  wire logic                        s_axi_wvalid,    // Write data valid.
    output logic                             s_axi_wready,    // Write data ready.
    output logic [1:0]                       s_axi_bresp,     // Write response.
    output logic                             s_axi_bvalid,    // Write response valid.
    input  wire logic                        s_axi_bready,    // Write response ready.
    input  wire logic [`IPSL_ADDR_W-1:0]     s_axi_araddr,    // Read address.
    input  wire logic                        s_axi_arvalid,   // Read address valid.
    output logic                             s_axi_arready,   // Read address ready.
    output logic [31:0]                      s_axi_rdata,     // Read data.
    output logic [1:0]                       s_axi_rresp,     // Read response.
    output logic                             s_axi_rvalid,    // Read data valid.
    input  wire logic                        s_axi_rready,    // Read data ready.
    input  wire logic [`IPSL_NUM_SRC-1:0]    src_flag,        // Source flag bits.
    input  wire logic [`IPSL_NUM_SRC-1:0]    src_enable,      // Source enable bits.
    input  wire logic [`IPSL_NUM_TRAP-1:0]   trap_req,        // Trap i requests at level 8+i.
    input  wire logic [3:0]                  cpu_level,       // Current processor priority level.
    input  wire logic                        nesting_disable, // Nesting disable control bit.
    input  wire logic                        in_service,      // Core is running a service routine.
    input  wire logic                        timed_mask,      // Timed mask instruction is active.
    input  wire logic                        cpu_ack,         // Core takes the presented request.
    output logic                             irq_req,         // Request to the core.
    output logic [3:0]                       irq_level,       // Level of the presented request.
    output logic [7:0]                       irq_vector       // Vector of the presented request.
);
    import ipsl_pkg::*;

    // Highest index first, so entry i is source i.
    localparam logic [`IPSL_NUM_SRC-1:0][7:0] SRC_VEC = {
        `IPSL_VEC_LOW_VOLT,
        `IPSL_VEC_SERIAL_ONE,
        `IPSL_VEC_SERIAL_TWO,
        `IPSL_VEC_CHECKSUM,
        `IPSL_VEC_CALENDAR,
        `IPSL_VEC_I2C_SLAVE,
        `IPSL_VEC_I2C_MASTER
    };

    ipsl_state_t st_q;
    ipsl_state_t st_d;

    logic [`IPSL_NUM_SRC-1:0] pend;
    logic [`IPSL_NUM_SRC-1:0] elig;
    logic [`IPSL_NUM_SRC-1:0] held_off;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-source qualification.
    // Eligible is pending with every mask applied.
    for (genvar i = 0; i < `IPSL_NUM_SRC; i++) begin : g_src
        assign pend[i]     = src_flag[i] && src_enable[i] && (st_q.lvl[i] != `IPSL_LEVEL_OFF);
        assign elig[i]     = pend[i] && ({1'b0, st_q.lvl[i]} > cpu_level)
                             && !(timed_mask && ({1'b0, st_q.lvl[i]} < `IPSL_LEVEL_TOP_USER))
                             && !(nesting_disable && in_service);
        assign held_off[i] = pend[i] && ({1'b0, st_q.lvl[i]} <= cpu_level);
    end

    // Highest level wins; on equal levels the SRC_VEC entries are compared, so ties keep the lowest vector.
    function automatic logic [3:0] pick(input logic [`IPSL_NUM_SRC-1:0] mask, input ipsl_levels_t lv);
        logic [3:0] idx;
        logic [2:0] best;
        logic [7:0] bvec;
        logic       any;

        idx  = 4'hf;
        best = 3'h0;
        bvec = 8'hff;
        any  = 1'b0;

        for (int k = 0; k < `IPSL_NUM_SRC; k++) begin
            if (mask[k] && (!any || lv[k] > best || (lv[k] == best && SRC_VEC[k] < bvec))) begin
                idx  = 4'(k);
                best = lv[k];
                bvec = SRC_VEC[k];
                any  = 1'b1;
            end
        end
        return idx;
    endfunction

    logic [3:0] win_idx;
    logic [3:0] pend_idx;
    logic       win_user;
    logic       win_trap;
    logic [2:0] trap_idx;
    logic       win_valid;
    logic [3:0] win_level;
    logic [7:0] win_vec;

    always_comb begin
        win_idx  = pick(elig, st_q.lvl);
        pend_idx = pick(pend, st_q.lvl);
        win_user = (elig != '0);
        win_trap = (trap_req != '0);
        trap_idx = 3'h0;
        for (int k = 0; k < `IPSL_NUM_TRAP; k++) begin
            if (trap_req[k]) begin
                trap_idx = 3'(k);
            end
        end

        win_valid = win_trap || win_user;

        // Traps outrank all users; top trap index wins.
        if (win_trap) begin
            win_level = `IPSL_TRAP_BASE_LVL + {1'b0, trap_idx};
            win_vec   = {5'h00, trap_idx};
        end else if (win_user) begin
            win_level = {1'b0, st_q.lvl[win_idx[2:0]]};
            win_vec   = SRC_VEC[win_idx[2:0]];
        end else begin
            win_level = 4'h0;
            win_vec   = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file and bus slave.
    // Address and data latch apart, in either order.
    logic                      have_aw;
    logic                      have_w;
    logic [`IPSL_ADDR_W-1:0]   wr_addr;
    logic [31:0]               wr_data;
    logic [3:0]                wr_strb;
    logic [15:0]               wr_mask;
    logic [15:0]               rd_word;
    logic                      rd_hit;
    logic                      wr_hit;

    function automatic logic [2:0] upd(input logic [2:0] old, input logic [15:0] d, input logic [15:0] m,
                                       input int pos);
        logic [2:0] r;

        r = old;
        for (int b = 0; b < 3; b++) begin
            if (m[pos+b]) begin
                r[b] = d[pos+b];
            end
        end
        return r;
    endfunction

    always_comb begin
        st_d    = st_q;
        have_aw = st_q.aw_held || (s_axi_awvalid && st_q.awready);
        have_w  = st_q.w_held || (s_axi_wvalid && st_q.wready);
        wr_addr = st_q.aw_held ? st_q.awaddr : s_axi_awaddr;
        wr_data = st_q.w_held ? st_q.wdata : s_axi_wdata;
        wr_strb = st_q.w_held ? st_q.wstrb : s_axi_wstrb;
        wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
        wr_hit  = 1'b1;

        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_held = 1'b1;
            st_d.awaddr  = s_axi_awaddr;
            st_d.awready = 1'b0;
        end

        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_held = 1'b1;
            st_d.wdata  = s_axi_wdata;
            st_d.wstrb  = s_axi_wstrb;
            st_d.wready = 1'b0;
        end

        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid  = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready  = 1'b1;
        end

        // Response follows both halves; readies wait for it.
        // Only implemented fields take write data; every other bit is left alone.
        if (have_aw && have_w && !st_q.bvalid) begin
            if (wr_addr == `IPSL_OFF_I2C_TWO) begin
                st_d.lvl[0] = upd(st_q.lvl[0], wr_data[15:0], wr_mask, `IPSL_POS_MID);
                st_d.lvl[1] = upd(st_q.lvl[1], wr_data[15:0], wr_mask, `IPSL_POS_LO);
            end else if (wr_addr == `IPSL_OFF_CALENDAR) begin
                st_d.lvl[2] = upd(st_q.lvl[2], wr_data[15:0], wr_mask, `IPSL_POS_MID);
            end else if (wr_addr == `IPSL_OFF_CHK_SERIAL) begin
                st_d.lvl[3] = upd(st_q.lvl[3], wr_data[15:0], wr_mask, `IPSL_POS_HI);
                st_d.lvl[4] = upd(st_q.lvl[4], wr_data[15:0], wr_mask, `IPSL_POS_MID);
                st_d.lvl[5] = upd(st_q.lvl[5], wr_data[15:0], wr_mask, `IPSL_POS_LO);
            end else if (wr_addr == `IPSL_OFF_LOW_VOLT) begin
                st_d.lvl[6] = upd(st_q.lvl[6], wr_data[15:0], wr_mask, `IPSL_POS_BOTTOM);
            end else if (wr_addr == `IPSL_OFF_STATUS) begin
                if (wr_strb[1]) begin
                    st_d.vector_capture_select = wr_data[`IPSL_POS_VECTOR_CAPTURE_SELECT];
                end
            end else begin
                wr_hit = 1'b0;
            end
            st_d.aw_held = 1'b0;
            st_d.w_held  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = wr_hit ? `IPSL_RESP_OKAY : `IPSL_RESP_SLVERR;
        end

        // Read data stands from acceptance until rready.
        rd_word = 16'h0000;
        rd_hit  = 1'b1;

        if (s_axi_araddr == `IPSL_OFF_I2C_TWO) begin
            rd_word[`IPSL_POS_MID+:3] = st_q.lvl[0];
            rd_word[`IPSL_POS_LO+:3]  = st_q.lvl[1];
        end else if (s_axi_araddr == `IPSL_OFF_CALENDAR) begin
            rd_word[`IPSL_POS_MID+:3] = st_q.lvl[2];
        end else if (s_axi_araddr == `IPSL_OFF_CHK_SERIAL) begin
            rd_word[`IPSL_POS_HI+:3]  = st_q.lvl[3];
            rd_word[`IPSL_POS_MID+:3] = st_q.lvl[4];
            rd_word[`IPSL_POS_LO+:3]  = st_q.lvl[5];
        end else if (s_axi_araddr == `IPSL_OFF_LOW_VOLT) begin
            rd_word[`IPSL_POS_BOTTOM+:3] = st_q.lvl[6];
        end else if (s_axi_araddr == `IPSL_OFF_STATUS) begin
            rd_word[`IPSL_POS_UNACK]     = st_q.unack;
            rd_word[`IPSL_POS_VECTOR_CAPTURE_SELECT]     = st_q.vector_capture_select;
            rd_word[`IPSL_POS_CPU_LVL+:4] = st_q.cpu_lvl;
            rd_word[6:0]                 = st_q.vec;
        end else begin
            rd_hit = 1'b0;
        end

        if (s_axi_arvalid && st_q.arready) begin
            st_d.arready = 1'b0;
            st_d.rvalid  = 1'b1;
            st_d.rdata   = {16'h0000, rd_word};
            st_d.rresp   = rd_hit ? `IPSL_RESP_OKAY : `IPSL_RESP_SLVERR;
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid  = 1'b0;
            st_d.arready = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Status capture and request to the core.
        // Status lags the core inputs by one cycle.
        st_d.cpu_lvl    = cpu_level;
        st_d.unack      = (held_off != '0) && !win_valid;
        st_d.irq_req    = win_valid;
        st_d.irq_level  = win_level;
        st_d.irq_vector = win_vec;

        // Trap vectors sit below the base, never captured.
        if (st_q.vector_capture_select) begin
            if (pend != '0) begin
                st_d.vec = 7'(SRC_VEC[pend_idx[2:0]] - `IPSL_VEC_BASE);
            end
        end else if (cpu_ack && st_q.irq_req && (st_q.irq_vector >= `IPSL_VEC_BASE)) begin
            st_d.vec = 7'(st_q.irq_vector - `IPSL_VEC_BASE);
        end
    end

    // Fields leave reset at level four, bus ready.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q         <= '0;
            st_q.lvl     <= {`IPSL_NUM_SRC{`IPSL_LEVEL_RESET}};
            st_q.awready <= 1'b1;
            st_q.wready  <= 1'b1;
            st_q.arready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state flops.
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready  = st_q.wready;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
    assign irq_req       = st_q.irq_req;
    assign irq_level     = st_q.irq_level;
    assign irq_vector    = st_q.irq_vector;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Outputs are checked a cycle after their cause.

    disabled_never_a: assert property (
        irq_req |-> irq_level != 4'h0)
        else $error("Source with zero priority was presented.");

    trap_unmasked_a: assert property (
        (trap_req != '0) |=> (irq_req && irq_level >= `IPSL_TRAP_BASE_LVL))
        else $error("Trap request was masked.");

    level_seven_mask_a: assert property (
        (cpu_level >= `IPSL_LEVEL_TOP_USER && trap_req == '0) |=> !irq_req)
        else $error("User interrupt passed processor level seven.");

    timed_mask_a: assert property (
        (timed_mask && trap_req == '0) |=> (!irq_req || irq_level == `IPSL_LEVEL_TOP_USER))
        else $error("Timed mask let a level below seven through.");

    nest_block_a: assert property (
        (nesting_disable && in_service && trap_req == '0) |=> !irq_req)
        else $error("Request pre-empted a routine with nesting disabled.");

    vector_hold_a: assert property (
        (!st_q.vector_capture_select && !st_d.vector_capture_select && !cpu_ack) |=> $stable(st_q.vec))
        else $error("Held vector field changed without an acknowledge.");

    ack_capture_a: assert property (
        (!st_q.vector_capture_select && cpu_ack && irq_req && irq_vector >= `IPSL_VEC_BASE)
        |=> {1'b0, st_q.vec} + `IPSL_VEC_BASE == $past(irq_vector))
        else $error("Acknowledged vector was not captured.");

    unack_flag_a: assert property (
        (held_off != '0 && !win_valid) |=> st_q.unack)
        else $error("Held-off request did not raise the status flag.");

    unack_clear_a: assert property (
        (held_off == '0 || win_valid) |=> !st_q.unack)
        else $error("Status flag set with nothing held off.");

    winner_level_a: assert property (
        (irq_req && irq_level < `IPSL_TRAP_BASE_LVL) |-> irq_level > $past(cpu_level))
        else $error("Winner does not exceed the processor level.");

    cpu_level_copy_a: assert property (
        1'b1 |=> st_q.cpu_lvl == $past(cpu_level))
        else $error("Level readback does not follow the core.");

    read_high_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("Unused read bits are not zero.");

    trap_vector_a: assert property (
        (irq_req && irq_level >= `IPSL_TRAP_BASE_LVL) |-> irq_vector == {4'h0, irq_level - 4'h8})
        else $error("Trap vector does not match its level.");

    vector_follow_a: assert property (
        (st_q.vector_capture_select && pend == '0) |=> $stable(st_q.vec))
        else $error("Vector field moved with nothing pending.");

endmodule // ipsl_top

// [verification/ipsl_core_model.sv]
// Behavioural processor core that accepts requests from the interrupt priority and status logic.
// Assumes the same clock and reset as the design; answers promptly or after a stall of three cycles.
`timescale 1ns/1ps

module ipsl_core_model (
    input  wire logic clk,        // System clock.
    input  wire logic rst,        // Asynchronous reset, active high.
    input  wire logic irq_req,    // Request presented by the design.
    input  wire logic slow,       // Stall before accepting.
    output logic      cpu_ack,    // One-cycle accept pulse.
    output logic      in_service  // A service routine is running.
);
    logic [2:0] wait_q;
    logic [2:0] run_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_ack    <= 1'h0;
            in_service <= 1'h0;
            wait_q     <= 3'h0;
            run_q      <= 3'h0;
        end else begin
            cpu_ack <= 1'h0;
            if (run_q != 3'h0) begin
                run_q      <= run_q - 3'h1;
                in_service <= (run_q != 3'h1);
            end
            if (irq_req && !cpu_ack) begin
                if (slow && wait_q < 3'h3) begin
                    wait_q <= wait_q + 3'h1;
                end else begin
                    cpu_ack    <= 1'h1;
                    wait_q     <= 3'h0;
                    in_service <= 1'h1;
                    run_q      <= 3'h4;
                end
            end
        end
    end
endmodule // ipsl_core_model

// [verification/tb_interrupt_priority_status_logic.sv]
// Self-checking bench for the interrupt priority and status logic.
// Assumes ipsl_cfg.svh on the include path and the core model beside the design.
`timescale 1ns/1ps
`include "ipsl_cfg.svh"

module tb_interrupt_priority_status_logic;
    import ipsl_pkg::*;
    logic        clk = 1'h0, rst = 1'h1, slow = 1'h0, vh = 1'h0, chk_on = 1'h0, chk_d = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, trap_req = 8'h00;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf, cpu_level = 4'h0;
    logic [6:0]  src_flag = 7'h00, src_enable = 7'h00, mvec;
    logic        nesting_disable = 1'h0, timed_mask = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        cpu_ack, in_service, irq_req;
    logic [3:0]  irq_level;
    logic [7:0]  irq_vector;
    logic [2:0]  lv [7];
    logic [12:0] exp_q = 13'h0, pn;
    int          num_errors = 0, n_compared = 0, cyc = 0;
    localparam logic [7:0] SA [7] = '{8'h00, 8'h00, 8'h04, 8'h08, 8'h08, 8'h08, 8'h0c};
    localparam int         SP [7] = '{8, 4, 8, 12, 8, 4, 0};
    localparam logic [7:0] VT [7] = '{`IPSL_VEC_I2C_MASTER, `IPSL_VEC_I2C_SLAVE, `IPSL_VEC_CALENDAR,
        `IPSL_VEC_CHECKSUM, `IPSL_VEC_SERIAL_TWO, `IPSL_VEC_SERIAL_ONE, `IPSL_VEC_LOW_VOLT};

    ipsl_top i_dut (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_flag, .src_enable, .trap_req, .cpu_level,
        .nesting_disable, .in_service, .timed_mask, .cpu_ack, .irq_req, .irq_level, .irq_vector
    );
    ipsl_core_model i_core (.clk, .rst, .irq_req, .slow, .cpu_ack, .in_service);

    always #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Presented request {valid, level, vector}; pend ignores the processor level and all masks.
    function automatic logic [12:0] arb(input logic pend);
        logic [12:0] r;
        r = 13'h0;
        for (int i = 0; i < 8; i++) if (!pend && trap_req[i]) r = {1'h1, 4'(8 + i), 8'(i)};
        if (r[12]) return r;
        for (int i = 0; i < 7; i++)
            if (src_flag[i] && src_enable[i] && lv[i] != 3'h0 && {1'h0, lv[i]} > r[11:8] && (pend ||
                ({1'h0, lv[i]} > cpu_level && !(timed_mask && lv[i] < 3'h7) && !(nesting_disable && in_service))))
                r = {1'h1, 1'h0, lv[i], VT[i]};
        return r;
    endfunction

    function automatic logic [31:0] regv(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 7; i++) if (SA[i] == a) r = r | (32'(lv[i]) << SP[i]);
        return r;
    endfunction

    function automatic logic [31:0] stat();
        logic        u;
        logic [12:0] r;
        u = 1'h0;
        r = arb(1'h0);
        for (int i = 0; i < 7; i++)
            if (src_flag[i] && src_enable[i] && lv[i] != 3'h0 && {1'h0, lv[i]} <= cpu_level) u = !r[12];
        return {16'h0, u, 1'h0, vh, 1'h0, cpu_level, 1'h0, mvec};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        chk("bresp", 32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", 32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reference model: outputs follow the inputs sampled one edge earlier.
    always @(posedge clk) begin
        if (chk_d) chk("irq", {19'h0, irq_req, irq_level, irq_vector}, 32'(exp_q));
        pn = arb(1'h1);
        if (rst) mvec <= 7'h00;
        else if (cpu_ack && exp_q[12] && exp_q[7:0] >= 8'h08 && !vh) mvec <= 7'(exp_q[7:0] - 8'h08);
        else if (vh && pn[12]) mvec <= 7'(pn[7:0] - 8'h08);
        exp_q <= rst ? 13'h0 : arb(1'h0);
        chk_d <= chk_on;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            final_report();
        end
    end

    initial begin
        logic [31:0] d;
        void'($urandom(32'hb50e));
        for (int i = 0; i < 7; i++) lv[i] = 3'h4;
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        for (int a = 0; a < 5; a++) rd(8'(a * 4), (a == 4) ? stat() : regv(8'(a * 4)), 2'h0);
        rd(8'h14, 32'h0, 2'h2);
        wr(8'h14, 32'hffffffff, 2'h2);
        for (int p = 0; p < 4; p++) begin
            for (int a = 0; a < 4; a++) begin
                d = (p == 0) ? 32'hffffffff : $urandom;
                s_axi_wstrb <= (p == 0) ? 4'hf : 4'($urandom);
                wr(8'(a * 4), d, 2'h0);
                for (int i = 0; i < 7; i++) if (SA[i] == 8'(a * 4) && s_axi_wstrb[SP[i] / 8]) lv[i] = d[SP[i] +: 3];
                rd(8'(a * 4), regv(8'(a * 4)), 2'h0);
            end
            chk_on <= 1'h1;
            repeat (300) begin
                @(posedge clk);
                src_flag <= 7'($urandom);
                src_enable <= 7'($urandom);
                trap_req <= ($urandom_range(15, 0) == 0) ? 8'($urandom) : 8'h00;
                cpu_level <= 4'($urandom_range(8, 0));
                nesting_disable <= 1'($urandom);
                timed_mask <= ($urandom_range(3, 0) == 0);
                slow <= 1'($urandom);
            end
            @(posedge clk);
            chk_on <= 1'h0;
            src_flag <= 7'h00;
            src_enable <= 7'h00;
            trap_req <= 8'h00;
            nesting_disable <= 1'h0;
            timed_mask <= 1'h0;
        end
        s_axi_wstrb <= 4'hf;
        wr(8'h04, 32'h00000500, 2'h0);
        lv[2] = 3'h5;
        cpu_level <= 4'h7;
        @(posedge clk);
        src_enable <= 7'h04;
        @(posedge clk);
        src_flag <= 7'h04;
        repeat (4) @(posedge clk);
        chk("irq_req", 32'(irq_req), 32'h0);
        rd(8'h10, stat(), 2'h0);
        wr(8'h10, 32'hffffffff, 2'h0);
        vh <= 1'h1;
        cpu_level <= 4'h0;
        repeat (4) @(posedge clk);
        rd(8'h10, stat(), 2'h0);
        final_report();
    end
endmodule // tb_interrupt_priority_status_logic
